// ==== verilog/rsc_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rsc_core_defines.svh"

// Contract
// - Each instruction is one 16-bit word
// - Basic instructions retire one per clock
// - 32-bit ALU; byte, word, longword memory
// - Loaded byte or word is sign-extended
// - Arithmetic immediates sign-, logic zero-extended
// - Data operations use registers only
// - Bitwise AND may act on memory
// - Unconditional branch runs delay slot first
// - 16x16 multiply gives 32 bits, 1-3 cycles
// - Multiply-accumulate into 42 bits, 2-3 cycles
// - Compares set flag; conditional branches read it
// - Only chosen instructions touch flag
// - Signed GE sets flag; flag branches follow
// - Test sets flag when AND is zero
// - 8-bit immediate sits in instruction
// - Wide constants load PC-relative from memory
// - PC displacement zero-extended, scaled; longword table base long-aligned
module rsc_core #(
  parameter int MUL_LAT = `RSC_MUL_LAT,
  parameter int MAC_LAT = `RSC_MAC_LAT
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  output logic                   imem_req,
  output logic [31:0]            imem_addr,
  input  wire logic [15:0]       imem_rdata,
  input  wire logic              imem_valid,
  output logic                   dmem_req,
  output logic                   dmem_we,
  output logic [31:0]            dmem_addr,
  output rsc_pkg::rsc_size_t     dmem_size,
  output logic [31:0]            dmem_wdata,
  input  wire logic [31:0]       dmem_rdata,
  input  wire logic              dmem_valid,
  output logic                   flag_t,
  output logic [41:0]            mac_acc
);
  import rsc_pkg::*;

  // General registers, no reset: software loads them
  logic [31:0]   regs_r [16];

  // Sequencer and control state
  rsc_state_t    state_r;       // Current state
  rsc_state_t    state_nxt;
  logic [31:0]   pc_r;          // Address of word being fetched
  logic [31:0]   pc_nxt;
  logic          pend_r;        // Branch waits behind its delay slot
  logic          pend_nxt;
  logic [31:0]   tgt_r;         // Held branch target
  logic [31:0]   tgt_nxt;
  logic          t_r;           // Condition flag
  logic          t_nxt;
  logic [3:0]    ldreg_r;       // Destination of a pending load
  logic [3:0]    ldreg_nxt;
  logic [7:0]    mimm_r;        // Mask for memory AND
  logic [7:0]    mimm_nxt;
  logic [1:0]    cnt_r;         // Multiplier latency count
  logic [1:0]    cnt_nxt;
  logic          macop_r;       // High for accumulate, low for plain
  logic          macop_nxt;
  logic [31:0]   prod_r;        // Latched product
  logic [31:0]   prod_nxt;
  logic [41:0]   acc_r;         // Accumulator
  logic [41:0]   acc_nxt;

  // Data port registers
  logic          dreq_r;
  logic          dreq_nxt;
  logic          dwe_r;
  logic          dwe_nxt;
  logic [31:0]   daddr_r;
  logic [31:0]   daddr_nxt;
  rsc_size_t     dsz_r;
  rsc_size_t     dsz_nxt;
  logic [31:0]   dwd_r;
  logic [31:0]   dwd_nxt;
  logic          ireq_r;        // Fetch request

  // Register file write port
  logic          rf_we;
  logic [3:0]    rf_wa;
  logic [31:0]   rf_wd;

  // Field decode of the fetched word
  wire [15:0]    ir  = imem_rdata;
  wire rsc_op_t  op  = rsc_op_t'(ir[`RSC_OP_MSB:`RSC_OP_LSB]);
  wire [3:0]     rn  = ir[`RSC_RN_MSB:`RSC_RN_LSB];
  wire [3:0]     rm  = ir[`RSC_RM_MSB:`RSC_RM_LSB];
  wire [7:0]     imm = ir[`RSC_IMM_MSB:`RSC_IMM_LSB];
  wire [31:0]    vn  = regs_r[rn];
  wire [31:0]    vm  = regs_r[rm];

  // Immediate extensions
  wire [31:0]    imm_sx = {{24{imm[7]}}, imm};
  wire [31:0]    imm_zx = {24'h00_0000, imm};

  // Sequential and look-ahead PC
  wire [31:0]    pc_seq = pc_r + `RSC_PC_STEP;
  wire [31:0]    pc_ahd = pc_r + `RSC_PC_AHEAD;

  // PC-relative table addresses, displacement zero-extended
  wire [31:0]    ea_pcw = pc_ahd + {23'h00_0000, imm, 1'b0};
  wire [31:0]    ea_pcl = (pc_ahd & `RSC_LONG_MASK)
                          + {22'h00_0000, imm, 2'b00};

  // Branch targets, halfword scaled
  wire [31:0]    tgt_jmp = pc_ahd
                 + {{19{ir[`RSC_BDISP_MSB]}}, ir[`RSC_BDISP_MSB:0], 1'b0};
  wire [31:0]    tgt_bc  = pc_ahd + {{23{imm[7]}}, imm, 1'b0};

  // Signed compare and test results
  wire           ge_res  = $signed(vn) >= $signed(vm);
  wire           andz_res = (vn & vm) == 32'h0000_0000;

  // Conditional branch decision; refused inside a delay slot
  wire           fset_take = (op == OP_BSET) && t_r && !pend_r;
  wire           fclr_take = (op == OP_BCLR) && !t_r && !pend_r;

  // Load data extended to a longword
  wire [31:0]    ld_ext = (dsz_r == SZ_B) ? {{24{dmem_rdata[7]}}, dmem_rdata[7:0]}
                        : (dsz_r == SZ_W) ? {{16{dmem_rdata[15]}}, dmem_rdata[15:0]}
                        : dmem_rdata;

  // Signed 16x16 product, always 32 bits
  wire [31:0]    prod_w = 32'($signed(vn[15:0]) * $signed(vm[15:0]));

  // Size field of the general load and store
  wire rsc_size_t msz = (ir[`RSC_SZ_MSB:`RSC_SZ_LSB] == SZ_B) ? SZ_B
                      : (ir[`RSC_SZ_MSB:`RSC_SZ_LSB] == SZ_W) ? SZ_W
                      : SZ_L;

  // Latency counts in counter width
  wire [1:0]     mul_cnt = 2'(MUL_LAT - 1);
  wire [1:0]     mac_cnt = 2'(MAC_LAT - 1);

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    pend_nxt  = pend_r;
    tgt_nxt   = tgt_r;
    t_nxt     = t_r;
    ldreg_nxt = ldreg_r;
    mimm_nxt  = mimm_r;
    cnt_nxt   = cnt_r;
    macop_nxt = macop_r;
    prod_nxt  = prod_r;
    acc_nxt   = acc_r;
    dreq_nxt  = dreq_r;
    dwe_nxt   = dwe_r;
    daddr_nxt = daddr_r;
    dsz_nxt   = dsz_r;
    dwd_nxt   = dwd_r;
    rf_we     = 1'b0;
    rf_wa     = rn;
    rf_wd     = 32'h0000_0000;
    case (state_r)
      S_EXEC: begin
        // One word consumed per valid beat
        // A word offered while no fetch is requested is ignored
        if (imem_valid && ireq_r) begin
          // Delay slot retires, then the held target takes over
          pc_nxt   = pend_r ? tgt_r : pc_seq;
          pend_nxt = 1'b0;
          case (op)
            OP_ADD: begin
              // Register to register; flag untouched
              rf_we = 1'b1;
              rf_wd = vn + vm;
            end
            OP_ADDI: begin
              // Negative immediate still leaves flag alone
              rf_we = 1'b1;
              rf_wd = vn + imm_sx;
            end
            OP_ANDI: begin
              // Upper 24 bits always cleared
              rf_we = 1'b1;
              rf_wd = vn & imm_zx;
            end
            OP_MOVI: begin
              rf_we = 1'b1;
              rf_wd = imm_sx;
            end
            OP_CMPGE: t_nxt = ge_res;
            OP_TAND:  t_nxt = andz_res;
            OP_LDPCW: begin
              // Word constant from the literal table
              dreq_nxt  = 1'b1;
              daddr_nxt = ea_pcw;
              dsz_nxt   = SZ_W;
              ldreg_nxt = rn;
              state_nxt = S_LOAD;
            end
            OP_LDPCL: begin
              // Longword constant, aligned table address
              dreq_nxt  = 1'b1;
              daddr_nxt = ea_pcl;
              dsz_nxt   = SZ_L;
              ldreg_nxt = rn;
              state_nxt = S_LOAD;
            end
            OP_LD: begin
              // Load through the address in Rm
              dreq_nxt  = 1'b1;
              daddr_nxt = vm;
              dsz_nxt   = msz;
              ldreg_nxt = rn;
              state_nxt = S_LOAD;
            end
            OP_ST: begin
              // Store Rm through the address in Rn
              dreq_nxt  = 1'b1;
              dwe_nxt   = 1'b1;
              daddr_nxt = vn;
              dsz_nxt   = msz;
              dwd_nxt   = vm;
              state_nxt = S_STORE;
            end
            OP_ANDM: begin
              // Byte read first, write back after masking
              dreq_nxt  = 1'b1;
              daddr_nxt = vn;
              dsz_nxt   = SZ_B;
              mimm_nxt  = imm;
              state_nxt = S_RMW_RD;
            end
            OP_JMP: begin
              // A branch in a slot would lose the first target
              if (!pend_r) begin
                pend_nxt = 1'b1;
                tgt_nxt  = tgt_jmp;
              end
            end
            OP_BSET, OP_BCLR: begin
              // Not delayed; flag written just before is seen
              if (fset_take || fclr_take) begin
                pc_nxt = tgt_bc;
              end
            end
            OP_MUL, OP_MAC: begin
              // Operands sampled now, result after the count
              prod_nxt  = prod_w;
              macop_nxt = (op == OP_MAC);
              cnt_nxt   = (op == OP_MAC) ? mac_cnt : mul_cnt;
              ldreg_nxt = rn;
              state_nxt = S_MUL;
            end
            default: begin
              pend_nxt = 1'b0;
            end
          endcase
        end
      end
      S_LOAD: begin
        // Extended data goes to the register file
        if (dmem_valid) begin
          dreq_nxt  = 1'b0;
          rf_we     = 1'b1;
          rf_wa     = ldreg_r;
          rf_wd     = ld_ext;
          state_nxt = S_EXEC;
        end
      end
      S_STORE: begin
        // Hold the request until accepted
        if (dmem_valid) begin
          dreq_nxt  = 1'b0;
          dwe_nxt   = 1'b0;
          state_nxt = S_EXEC;
        end
      end
      S_RMW_RD: begin
        // Same byte address, now a write
        if (dmem_valid) begin
          dwe_nxt   = 1'b1;
          dwd_nxt   = {24'h00_0000, dmem_rdata[7:0] & mimm_r};
          state_nxt = S_RMW_WR;
        end
      end
      S_RMW_WR: begin
        if (dmem_valid) begin
          dreq_nxt  = 1'b0;
          dwe_nxt   = 1'b0;
          state_nxt = S_EXEC;
        end
      end
      S_MUL: begin
        // Commit once the latency count runs out
        if (cnt_r == 2'h0) begin
          state_nxt = S_EXEC;
          if (macop_r) begin
            acc_nxt = acc_r + {{10{prod_r[31]}}, prod_r};
          end else begin
            rf_we = 1'b1;
            rf_wa = ldreg_r;
            rf_wd = prod_r;
          end
        end else begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      default: begin
        state_nxt = S_EXEC;
      end
    endcase
  end

  // Register file write, frozen with the enable
  always_ff @(posedge sys_clk) begin
    if (clk_en && rf_we) begin
      regs_r[rf_wa] <= rf_wd;
    end
  end

  // Sequencer state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_EXEC;
      pc_r    <= `RSC_RESET_PC;
      pend_r  <= 1'b0;
      tgt_r   <= `RSC_RESET_PC;
      t_r     <= `RSC_FLAG_RST;
    end else if (clk_en) begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      pend_r  <= pend_nxt;
      tgt_r   <= tgt_nxt;
      t_r     <= t_nxt;
    end
  end

  // Operand holding registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ldreg_r <= 4'h0;
      mimm_r  <= 8'h00;
      cnt_r   <= 2'h0;
      macop_r <= 1'b0;
      prod_r  <= 32'h0000_0000;
      acc_r   <= `RSC_ACC_RST;
    end else if (clk_en) begin
      ldreg_r <= ldreg_nxt;
      mimm_r  <= mimm_nxt;
      cnt_r   <= cnt_nxt;
      macop_r <= macop_nxt;
      prod_r  <= prod_nxt;
      acc_r   <= acc_nxt;
    end
  end

  // Data port; fetch request only while executing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dreq_r  <= 1'b0;
      dwe_r   <= 1'b0;
      daddr_r <= 32'h0000_0000;
      dsz_r   <= SZ_B;
      dwd_r   <= 32'h0000_0000;
      ireq_r  <= 1'b0;
    end else if (clk_en) begin
      dreq_r  <= dreq_nxt;
      dwe_r   <= dwe_nxt;
      daddr_r <= daddr_nxt;
      dsz_r   <= dsz_nxt;
      dwd_r   <= dwd_nxt;
      ireq_r  <= (state_nxt == S_EXEC);
    end
  end

  // Outputs, all flip-flops
  assign imem_req   = ireq_r;
  assign imem_addr  = pc_r;
  assign dmem_req   = dreq_r;
  assign dmem_we    = dwe_r;
  assign dmem_addr  = daddr_r;
  assign dmem_size  = dsz_r;
  assign dmem_wdata = dwd_r;
  assign flag_t     = t_r;
  assign mac_acc    = acc_r;

endmodule : rsc_core
`default_nettype wire

// ==== verilog/rsc_core_defines.svh ====
`ifndef RSC_CORE_DEFINES_SVH
`define RSC_CORE_DEFINES_SVH

// Instruction word and field positions
`define RSC_IW_BITS     16
`define RSC_OP_MSB      15
`define RSC_OP_LSB      12
`define RSC_RN_MSB      11
`define RSC_RN_LSB      8
`define RSC_RM_MSB      7
`define RSC_RM_LSB      4
`define RSC_IMM_MSB     7
`define RSC_IMM_LSB     0
`define RSC_BDISP_MSB   11
`define RSC_SZ_MSB      1
`define RSC_SZ_LSB      0

// Program counter
`define RSC_RESET_PC    32'h0000_0000
`define RSC_PC_STEP     32'h0000_0002
`define RSC_PC_AHEAD    32'h0000_0004
`define RSC_LONG_MASK   32'hffff_fffc

// Timing
`define RSC_INSTR_NS    50
`define RSC_REF_MHZ     20
`define RSC_CLK_MHZ     250
`define RSC_BASIC_CYC   1
`define RSC_MUL_LAT     1
`define RSC_MAC_LAT     2

// Reset values of control state
`define RSC_FLAG_RST    1'b0
`define RSC_ACC_RST     42'h000_0000_0000

`endif

// ==== verilog/rsc_pkg.sv ====
`default_nettype none
package rsc_pkg;

  // Sequencer states
  typedef enum {
    S_EXEC,
    S_LOAD,
    S_STORE,
    S_RMW_RD,
    S_RMW_WR,
    S_MUL
  } rsc_state_t;

  // Opcode in the top nibble
  typedef enum logic [3:0] {
    OP_ADD   = 4'h0,
    OP_ADDI  = 4'h1,
    OP_ANDI  = 4'h2,
    OP_MOVI  = 4'h3,
    OP_CMPGE = 4'h4,
    OP_TAND  = 4'h5,
    OP_LDPCW = 4'h6,
    OP_LDPCL = 4'h7,
    OP_LD    = 4'h8,
    OP_ST    = 4'h9,
    OP_ANDM  = 4'ha,
    OP_JMP   = 4'hb,
    OP_BSET  = 4'hc,
    OP_BCLR  = 4'hd,
    OP_MUL   = 4'he,
    OP_MAC   = 4'hf
  } rsc_op_t;

  // Memory access size
  typedef enum logic [1:0] {
    SZ_B = 2'h0,
    SZ_W = 2'h1,
    SZ_L = 2'h2
  } rsc_size_t;

endpackage : rsc_pkg
`default_nettype wire

// ==== dv/rsc_core_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_core_sva #(
  parameter int MUL_LAT = 1,
  parameter int MAC_LAT = 2
) (
  input wire logic               sys_clk,
  input wire logic               arst_n,
  input wire logic               clk_en,
  input wire logic               imem_req,
  input wire logic [31:0]        imem_addr,
  input wire logic [15:0]        imem_rdata,
  input wire logic               imem_valid,
  input wire logic               dmem_req,
  input wire logic               dmem_we,
  input wire logic [31:0]        dmem_addr,
  input wire rsc_pkg::rsc_size_t dmem_size,
  input wire logic [31:0]        dmem_wdata,
  input wire logic [31:0]        dmem_rdata,
  input wire logic               dmem_valid,
  input wire logic               flag_t,
  input wire logic [41:0]        mac_acc
);
  import rsc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic        taken;    // Fetch accepted at this edge
  logic [3:0]  op;       // Opcode of the fetched word
  logic        slot_r;   // Next fetch is a delay slot
  logic [31:0] tgt_r;    // Pending unconditional target
  logic        rmw_r;    // Last instruction was memory AND
  logic [7:0]  imm_r;    // Its mask
  assign taken = clk_en && imem_req && imem_valid;
  assign op    = imem_rdata[15:12];
  // Track delay slot and target; a branch inside a slot is ignored
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_r <= 1'b0;
      tgt_r  <= 32'h0;
      rmw_r  <= 1'b0;
      imm_r  <= 8'h0;
    end else if (taken) begin
      slot_r <= (op == OP_JMP) && !slot_r;
      rmw_r  <= (op == OP_ANDM);
      imm_r  <= imem_rdata[7:0];
      if ((op == OP_JMP) && !slot_r) begin
        tgt_r <= imem_addr + 32'h4 + {{19{imem_rdata[11]}}, imem_rdata[11:0], 1'b0};
      end
    end
  end
  a_fetch_hold: assert property (clk_en && imem_req && !imem_valid |=> imem_req && $stable(imem_addr))
    else $error("fetch address moved without an answer");
  a_pc_step: assert property (taken && !slot_r && op < 4'h6 |=> imem_req && imem_addr == $past(imem_addr) + 32'h2)
    else $error("basic instruction did not retire in one cycle");
  a_freeze_state: assert property (!clk_en |=> $stable(imem_addr) && $stable(dmem_req) && $stable(flag_t))
    else $error("state moved while clock enable low");
  a_slot_first: assert property (taken && op == OP_JMP && !slot_r |=> imem_addr == $past(imem_addr) + 32'h2)
    else $error("delay slot not fetched after branch");
  a_bra_target: assert property (taken && slot_r && op < 4'h6 |=> imem_addr == tgt_r)
    else $error("branch target wrong after delay slot");
  a_flag_only: assert property (!(taken && (op == OP_CMPGE || op == OP_TAND)) |=> $stable(flag_t))
    else $error("flag changed by another instruction");
  a_mul_lat: assert property (taken && op == OP_MUL |=> !imem_req ##MUL_LAT imem_req)
    else $error("multiply latency wrong");
  a_mac_lat: assert property (taken && op == OP_MAC |=> !imem_req ##MAC_LAT imem_req)
    else $error("accumulate latency wrong");
  a_load_regs: assert property (taken && op == OP_LD |=> dmem_req && !dmem_we && !imem_req)
    else $error("load did not go through memory port");
  a_rmw_write: assert property (dmem_req && dmem_valid && clk_en && !dmem_we && rmw_r
    |=> dmem_req && dmem_we && $stable(dmem_addr) && dmem_size == SZ_B
    && dmem_wdata[7:0] == ($past(dmem_rdata[7:0]) & imm_r))
    else $error("memory AND write-back wrong");
  a_pcrel_long: assert property (taken && op == OP_LDPCL |=> dmem_req
    && dmem_addr == ((($past(imem_addr) + 32'h4) & 32'hffff_fffc) + {22'h0, $past(imem_rdata[7:0]), 2'b00}))
    else $error("pc-relative long address wrong");
endmodule : rsc_core_sva
bind rsc_core rsc_core_sva #(.MUL_LAT(MUL_LAT), .MAC_LAT(MAC_LAT)) i_sva (
  .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .imem_req(imem_req), .imem_addr(imem_addr),
  .imem_rdata(imem_rdata), .imem_valid(imem_valid), .dmem_req(dmem_req), .dmem_we(dmem_we),
  .dmem_addr(dmem_addr), .dmem_size(dmem_size), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
  .dmem_valid(dmem_valid), .flag_t(flag_t), .mac_acc(mac_acc));
`default_nettype wire

// ==== dv/rsc_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_mem_model (
  input wire logic               sys_clk,
  input wire logic               arst_n,
  input wire logic [3:0]         wait_cyc,
  input wire logic               imem_req,
  input wire logic [31:0]        imem_addr,
  output logic [15:0]            imem_rdata,
  output logic                   imem_valid,
  input wire logic               dmem_req,
  input wire logic               dmem_we,
  input wire logic [31:0]        dmem_addr,
  input wire rsc_pkg::rsc_size_t dmem_size,
  input wire logic [31:0]        dmem_wdata,
  output logic [31:0]            dmem_rdata,
  output logic                   dmem_valid
);
  import rsc_pkg::*;
  logic [15:0] prog [0:63];  // Program, one word per instruction
  logic [7:0]  dmem [0:1023]; // Data bytes, little endian
  logic [31:0] ilast_r;       // Address seen last cycle
  logic [32:0] dlast_r;       // Address and direction seen last cycle
  int          icnt_r;        // Wait counters
  int          dcnt_r;
  int          icnt;
  int          dcnt;
  logic [9:0]  da;
  logic [31:0] rd;
  // Wait count restarts whenever the request changes
  assign icnt = (imem_addr == ilast_r) ? icnt_r : 0;
  assign dcnt = ({dmem_addr, dmem_we} == dlast_r) ? dcnt_r : 0;
  assign imem_valid = imem_req && (icnt >= wait_cyc);
  // Off-answer lines show inverted data, never a stale copy
  assign imem_rdata = imem_valid ? prog[imem_addr[6:1]] : ~prog[imem_addr[6:1]];
  assign da = dmem_addr[9:0];
  assign rd = {dmem[da + 10'd3], dmem[da + 10'd2], dmem[da + 10'd1], dmem[da]};
  assign dmem_valid = dmem_req && (dcnt >= wait_cyc);
  assign dmem_rdata = dmem_valid ? rd : ~rd;
  // Wait state counters
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ilast_r <= 32'hffff_ffff;
      dlast_r <= 33'h0;
      icnt_r  <= 0;
      dcnt_r  <= 0;
    end else begin
      ilast_r <= imem_addr;
      dlast_r <= {dmem_addr, dmem_we};
      icnt_r  <= imem_req ? icnt + 1 : 0;
      dcnt_r  <= dmem_req ? dcnt + 1 : 0;
    end
  end
  // Writes; plain always since the bench also preloads the array
  always @(posedge sys_clk) begin
    if (dmem_req && dmem_we && dmem_valid) begin
      dmem[da] <= dmem_wdata[7:0];
      if (dmem_size != SZ_B) begin
        dmem[da + 10'd1] <= dmem_wdata[15:8];
      end
      if (dmem_size[1]) begin
        dmem[da + 10'd2] <= dmem_wdata[23:16];
        dmem[da + 10'd3] <= dmem_wdata[31:24];
      end
    end
  end
endmodule : rsc_mem_model
`default_nettype wire

// ==== dv/rsc_core_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_core_tb;
  import rsc_pkg::*;
  // One row: opcode word, R1 and R2 seeds, checked address, value, flag
  typedef struct packed {
    logic [15:0] op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [9:0]  ca;
    logic [31:0] ex;
    logic        ef;
  } rsc_row_t;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  wait_cyc = 4'h0;
  logic        imem_req, imem_valid, dmem_req, dmem_we, dmem_valid, flag_t;
  logic [31:0] imem_addr, dmem_addr, dmem_wdata, dmem_rdata;
  logic [15:0] imem_rdata;
  logic [41:0] mac_acc;
  rsc_size_t   dmem_size;
  logic [15:0] pg [0:10];  // Program under test
  int          fail_count = 0;
  int          comparisons = 0;
  int          i, s;
  rsc_row_t rows [0:16] = '{
    '{16'h0120, 8'h05, 8'h07, 10'h40, 32'h0000_000c, 1'b0},
    '{16'h11ff, 8'h05, 8'h00, 10'h40, 32'h0000_0004, 1'b0},
    '{16'h2180, 8'h81, 8'h00, 10'h40, 32'h0000_0080, 1'b0},
    '{16'h3180, 8'h00, 8'h00, 10'h40, 32'hffff_ff80, 1'b0},
    '{16'h4120, 8'hfe, 8'h01, 10'h40, 32'hffff_fffe, 1'b0},
    '{16'h4120, 8'h01, 8'hfe, 10'h40, 32'h0000_0001, 1'b1},
    '{16'h5120, 8'h0f, 8'hf0, 10'h40, 32'h0000_000f, 1'b1},
    '{16'h5120, 8'h0f, 8'h01, 10'h40, 32'h0000_000f, 1'b0},
    '{16'he120, 8'hfe, 8'h03, 10'h40, 32'hffff_fffa, 1'b0},
    '{16'h8120, 8'h00, 8'h50, 10'h40, 32'hffff_ff85, 1'b0},
    '{16'h8121, 8'h00, 8'h50, 10'h40, 32'hffff_8085, 1'b0},
    '{16'h8122, 8'h00, 8'h50, 10'h40, 32'h0012_8085, 1'b0},
    '{16'h6180, 8'h00, 8'h00, 10'h40, 32'hffff_9234, 1'b0},
    '{16'h7180, 8'h00, 8'h00, 10'h40, 32'h1234_5678, 1'b0},
    '{16'ha10f, 8'h60, 8'h00, 10'h60, 32'h0000_0005, 1'b0},
    '{16'h9120, 8'h44, 8'h81, 10'h44, 32'h5a5a_5a81, 1'b0},
    '{16'h9121, 8'h48, 8'h81, 10'h48, 32'h5a5a_ff81, 1'b0}};
  rsc_core i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .imem_req(imem_req),
    .imem_addr(imem_addr), .imem_rdata(imem_rdata), .imem_valid(imem_valid), .dmem_req(dmem_req),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_size(dmem_size), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata), .dmem_valid(dmem_valid), .flag_t(flag_t), .mac_acc(mac_acc));
  rsc_mem_model i_mem (.sys_clk(sys_clk), .arst_n(arst_n), .wait_cyc(wait_cyc), .imem_req(imem_req),
    .imem_addr(imem_addr), .imem_rdata(imem_rdata), .imem_valid(imem_valid), .dmem_req(dmem_req),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_size(dmem_size), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata), .dmem_valid(dmem_valid));
  always #2 sys_clk = ~sys_clk;
  task chk_val(input logic [41:0] exp, input logic [41:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_val
  task chk_bit(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_bit
  function logic [31:0] rd32(input int a);
    return {i_mem.dmem[a + 3], i_mem.dmem[a + 2], i_mem.dmem[a + 1], i_mem.dmem[a]};
  endfunction : rd32
  task set32(input int a, input logic [31:0] v);
    for (int b = 0; b < 4; b++) i_mem.dmem[a + b] = v[8 * b +: 8];
  endtask : set32
  // Load program and data, reset, optionally stall, wait for the final store
  task run(input logic stall);
    int k;
    arst_n = 1'b0;
    for (k = 0; k < 64; k++) i_mem.prog[k] = (k < 11) ? pg[k] : 16'h0330;
    for (k = 0; k < 1024; k++) i_mem.dmem[k] = 8'h5a;
    set32(32'h50, 32'h0012_8085);
    set32(32'h10a, 32'h0000_9234);
    set32(32'h208, 32'h1234_5678);
    set32(32'h60, 32'h0000_00f5);
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    if (stall) begin
      repeat (3) @(negedge sys_clk);
      clk_en = 1'b0;
      repeat (5) @(negedge sys_clk);
      clk_en = 1'b1;
    end
    k = 0;
    while (!(dmem_req && dmem_we && dmem_valid && dmem_addr == 32'h40) && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    chk_bit(1'b1, k < 400);
    repeat (2) @(negedge sys_clk);
  endtask : run
  task end_of_test;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // Watchdog, more than ten times the expected run length
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  initial begin
    // Table, with prompt and with slow memory
    for (s = 0; s < 2; s++) begin
      wait_cyc = 4'(s * 2);
      for (i = 0; i < 17; i++) begin
        pg = '{16'h3040, {8'h31, rows[i].a}, {8'h32, rows[i].b}, rows[i].op, 16'h9012, 16'hbffe,
          16'h0330, 16'h0330, 16'h0330, 16'h0330, 16'h0330};
        run(1'b0);
        chk_val({10'h0, rows[i].ex}, {10'h0, rd32(rows[i].ca)});
        chk_bit(rows[i].ef, flag_t);
        $display("row %0d wait %0d done", i, s * 2);
      end
    end
    wait_cyc = 4'h1;
    // Slot runs once before the target, with a clock-enable stall
    pg = '{16'h3040, 16'hb001, 16'h3111, 16'h3122, 16'h9012, 16'hbffe, 16'h0330, 16'h0330, 16'h0330,
      16'h0330, 16'h0330};
    run(1'b1);
    chk_val(42'h11, {10'h0, rd32(32'h40)});
    $display("delay slot done");
    // Flag survives add, then set and clear branches
    for (i = 0; i < 2; i++) begin
      pg = '{16'h3040, 16'h3101, 16'h3202, 16'h4210, 16'h12ff, (i == 0) ? 16'hc101 : 16'hd101, 16'h3177,
        16'h3177, 16'h9012, 16'hbffe, 16'h0330};
      run(1'b0);
      chk_val((i == 0) ? 42'h1 : 42'h77, {10'h0, rd32(32'h40)});
      chk_bit(1'b1, flag_t);
      $display("conditional branch %0d done", i);
    end
    // Two accumulates of 3 times -2
    pg = '{16'h3040, 16'h3103, 16'h32fe, 16'hf120, 16'hf120, 16'h9012, 16'hbffe, 16'h0330, 16'h0330,
      16'h0330, 16'h0330};
    run(1'b0);
    chk_val(42'h3ff_ffff_fff4, mac_acc);
    // Reset in mid-run clears outputs
    arst_n = 1'b0;
    @(negedge sys_clk);
    chk_val(42'h0, mac_acc);
    chk_bit(1'b0, imem_req | dmem_req | flag_t);
    $display("accumulate and reset done");
    end_of_test();
  end
endmodule : rsc_core_tb
`default_nettype wire
